// ### core/dpath_defines.vh
`ifndef DPATH_DEFINES_VH
`define DPATH_DEFINES_VH

// Operation codes on the command port
`define OP_MOVE_BYTE 4'h0
`define OP_EXCHANGE_BYTE 4'h1
`define OP_MOVE_WORD 4'h2
`define OP_EXCHANGE_WORD 4'h3
`define OP_ADD 4'h4
`define OP_ADD_WITH_CARRY 4'h5
`define OP_SUB 4'h6
`define OP_SUBTRACT_WITH_BORROW 4'h7
`define OP_AND 4'h8
`define OP_OR 4'h9
`define OP_XOR 4'ha
`define OP_BIT_SET 4'hb
`define OP_BIT_CLEAR 4'hc
`define OP_BRANCH_REL 4'hd
`define OP_CALL_TABLE 4'he

// Operand location forms
`define FORM_IMM 4'h0
`define FORM_REG 4'h1
`define FORM_SADDR 4'h2
`define FORM_SFR 4'h3
`define FORM_ABS 4'h4
`define FORM_DE 4'h5
`define FORM_HL 4'h6
`define FORM_HL_BYTE 4'h7
`define FORM_PSW 4'h8

// Working register indices
`define IDX_X 3'h0
`define IDX_A 3'h1
`define IDX_C 3'h2
`define IDX_B 3'h3
`define IDX_E 3'h4
`define IDX_D 3'h5
`define IDX_L 3'h6
`define IDX_H 3'h7
`define PAIR_AX 2'h0

// Address windows
`define SADDR_LO 16'hfe20
`define SADDR_HI 16'hff1f
`define CALL_TABLE_LO 16'h0040
`define CALL_TABLE_HI 16'h007f

// Program status word layout and reset values
`define PSW_Z_BIT 6
`define PSW_HC_BIT 4
`define PSW_CY_BIT 0
`define PSW_RESET 8'h00
`define REG_RESET 8'h00

// Instruction lengths in CPU clocks
`define CYC_SHORT 4'h4
`define CYC_MID 4'h6
`define CYC_LONG 4'h8

`endif

// ### core/dpath_tick.v
`timescale 1ns/1ps
`include "dpath_defines.vh"

module dpath_tick
(
  // Clock and reset
  input wire MCLK,
  input wire RST_B,
  // Rate select: divide by 1, 2, 4 or 8
  input wire [1:0] sel,
  // One-cycle CPU clock enable
  output wire tick
);

  reg [2:0] cnt_ff;
  wire [3:0] limit;

  assign limit = (4'h1 << sel) - 4'h1;
  // Compare with >= so a rate change mid-count cannot strand the counter
  assign tick = ({1'b0, cnt_ff} >= limit);

  always @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      cnt_ff <= 3'h0;
    else if (tick)
      cnt_ff <= 3'h0;
    else
      cnt_ff <= cnt_ff + 3'h1;
  end

endmodule

// ### core/dpath_alu.v
`timescale 1ns/1ps
`include "dpath_defines.vh"

module dpath_alu
(
  // Operands
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  // Result and flags
  output reg [7:0] res,
  output wire z,
  output reg hc,
  output reg cy
);

  wire use_c;
  wire [8:0] sum;
  wire [4:0] sum_lo;
  wire [8:0] dif;
  wire [4:0] dif_lo;

  assign use_c = cin & ((op == `OP_ADD_WITH_CARRY) | (op == `OP_SUBTRACT_WITH_BORROW));
  assign sum = {1'b0, a} + {1'b0, b} + {8'h00, use_c};
  assign sum_lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, use_c};
  assign dif = {1'b0, a} - {1'b0, b} - {8'h00, use_c};
  assign dif_lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, use_c};
  assign z = (res == 8'h00);

  always @*
  begin
    res = 8'h00;
    hc = 1'b0;
    cy = 1'b0;
    case (op)
      `OP_ADD, `OP_ADD_WITH_CARRY:
      begin
        res = sum[7:0];
        cy = sum[8];
        hc = sum_lo[4];
      end
      `OP_SUB, `OP_SUBTRACT_WITH_BORROW:
      begin
        res = dif[7:0];
        cy = dif[8];
        hc = dif_lo[4];
      end
      `OP_AND: res = a & b;
      `OP_OR: res = a | b;
      `OP_XOR: res = a ^ b;
      default: res = 8'h00;
    endcase
  end

endmodule

// ### core/dpath_core.v
// Contract
// - Eight byte registers X,A,C,B,E,D,L,H indexed 0-7
// - Four pairs AX,BC,DE,HL; first register high
// - Short direct window FE20-FF1F; words even
// - Absolute addresses full range; word transfers even
// - Call-table index even, 0040 to 007F
// - Relative offset is signed eight-bit
// - Bit number selects bit 0-7
// - Each flag unchanged, cleared, set, computed, restored
// - Clocks counted in selected CPU clock periods
// - Add immediate: sum, carry, zero, half; 4 clocks
// - Add with carry includes carry; 4 clocks
// - Subtract immediate: borrow into carry; 4 clocks
// - Subtract with borrow includes carry; 4 clocks
// - Short direct immediate arithmetic: RMW, 6 clocks
// - AND updates only zero flag
// - OR updates only zero; immediate 4 clocks
// - XOR on short direct writes back; 6 clocks
// - Based-indexed address is HL plus unsigned byte
// - Exchange with based-indexed: no flags, 8 clocks
// - Word move/exchange partner only BC, DE, HL
// - Carry, half carry, zero follow the result
`timescale 1ns/1ps
`include "dpath_defines.vh"

module dpath_core
(
  // Clock and reset
  input wire MCLK,
  input wire RST_B,
  // CPU clock select
  input wire [1:0] CPU_CLK_SEL,
  // Command
  input wire CMD_VALID,
  output wire CMD_READY,
  input wire [3:0] CMD_OP,
  input wire [3:0] CMD_FORM,
  input wire CMD_DIR,
  input wire CMD_SRC_IMM,
  input wire [2:0] CMD_REG,
  input wire [1:0] CMD_PAIR,
  input wire [7:0] CMD_BYTE,
  input wire [15:0] CMD_WORD,
  input wire [2:0] CMD_BIT,
  // Completion
  output wire CMD_DONE,
  output wire CMD_ERR,
  output wire BUSY,
  output wire [15:0] TARGET_PC,
  // Memory and special function registers
  output wire [15:0] MEM_ADDR,
  output wire MEM_RD,
  output wire MEM_WR,
  output wire [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA,
  // Visible state
  output wire [7:0] PSW_OUT,
  output wire [7:0] ACC_OUT,
  input wire [2:0] PEEK_IDX,
  output wire [7:0] PEEK_DATA
);

  localparam S_IDLE = 7'b0000001;
  localparam S_RD = 7'b0000010;
  localparam S_RD2 = 7'b0000100;
  localparam S_EXEC = 7'b0001000;
  localparam S_WR = 7'b0010000;
  localparam S_WR2 = 7'b0100000;
  localparam S_WAIT = 7'b1000000;

  reg [6:0] state_ff;
  reg [3:0] op_ff;
  reg [3:0] form_ff;
  reg dir_ff;
  reg simm_ff;
  reg [2:0] reg_ff;
  reg [1:0] pair_ff;
  reg [7:0] byte_ff;
  reg [15:0] word_ff;
  reg [2:0] bit_ff;
  reg [3:0] clocks_ff;
  reg [3:0] cnt_ff;
  reg rd_word_ff;
  reg wr_ff;
  reg wr_word_ff;
  reg [7:0] tmp_ff;
  reg [15:0] addr_ff;
  reg [7:0] wdata_ff;
  reg [7:0] whi_ff;
  reg [15:0] target_ff;
  reg [7:0] psw_ff;
  reg done_ff;
  reg err_ff;

  wire tick;
  wire go;
  wire [63:0] regs_flat;
  wire [7:0] a_val;
  wire [7:0] x_val;
  wire [7:0] r_val;
  wire [7:0] ph_val;
  wire [7:0] pl_val;
  wire [7:0] alu_a;
  wire [7:0] alu_b;
  wire [7:0] alu_res;
  wire alu_z;
  wire alu_hc;
  wire alu_cy;
  wire [3:0] cmd_clocks;
  wire in_saddr;
  wire in_table;
  wire is_mem;
  wire needs_rd;
  wire legal;
  wire [15:0] hl_val;
  wire [15:0] de_val;
  reg [15:0] eff_addr;
  reg [7:0] src_b;
  reg [7:0] mv;
  reg [7:0] reg_we;
  reg [63:0] reg_wd;
  reg [7:0] psw_nxt;
  reg [7:0] wlo_nxt;
  reg [7:0] whi_nxt;
  reg [15:0] target_nxt;

  // Length of each accepted operation; zero marks an unsupported combination
  function [3:0] clocks_of;
    input [3:0] op;
    input [3:0] form;
    input dir;
    input simm;
    input [2:0] r;
    begin
      clocks_of = 4'h0;
      case (op)
        `OP_MOVE_BYTE:
          if (dir && simm)
            clocks_of = (form == `FORM_REG || form == `FORM_SADDR || form == `FORM_SFR || form == `FORM_PSW) ?
              `CYC_MID : 4'h0;
          else if (!simm)
            case (form)
              `FORM_REG, `FORM_SADDR, `FORM_SFR, `FORM_PSW: clocks_of = `CYC_SHORT;
              `FORM_ABS: clocks_of = `CYC_LONG;
              `FORM_DE, `FORM_HL, `FORM_HL_BYTE: clocks_of = `CYC_MID;
              default: clocks_of = 4'h0;
            endcase
        `OP_EXCHANGE_BYTE:
          if (!dir && !simm)
            case (form)
              `FORM_REG: clocks_of = (r == `IDX_X) ? `CYC_SHORT : `CYC_MID;
              `FORM_SADDR, `FORM_SFR: clocks_of = `CYC_MID;
              `FORM_DE, `FORM_HL, `FORM_HL_BYTE: clocks_of = `CYC_LONG;
              default: clocks_of = 4'h0;
            endcase
        `OP_MOVE_WORD:
          if (form == `FORM_IMM && dir && simm)
            clocks_of = `CYC_MID;
          else if (form == `FORM_REG && !simm)
            clocks_of = `CYC_SHORT;
          else if (form == `FORM_SADDR && !simm)
            clocks_of = dir ? `CYC_LONG : `CYC_MID;
        `OP_EXCHANGE_WORD:
          if (form == `FORM_REG && !dir && !simm)
            clocks_of = `CYC_LONG;
        `OP_ADD, `OP_ADD_WITH_CARRY, `OP_SUB, `OP_SUBTRACT_WITH_BORROW, `OP_AND, `OP_OR, `OP_XOR:
          if (dir)
            clocks_of = (form == `FORM_SADDR && simm) ? `CYC_MID : 4'h0;
          else if (!simm)
            case (form)
              `FORM_IMM, `FORM_REG, `FORM_SADDR: clocks_of = `CYC_SHORT;
              `FORM_ABS: clocks_of = `CYC_LONG;
              `FORM_HL, `FORM_HL_BYTE: clocks_of = `CYC_MID;
              default: clocks_of = 4'h0;
            endcase
        `OP_BIT_SET, `OP_BIT_CLEAR: clocks_of = `CYC_SHORT;
        `OP_BRANCH_REL: clocks_of = `CYC_MID;
        `OP_CALL_TABLE: clocks_of = `CYC_LONG;
        default: clocks_of = 4'h0;
      endcase
    end
  endfunction

  dpath_tick u_tick
  (
    .MCLK(MCLK),
    .RST_B(RST_B),
    .sel(CPU_CLK_SEL),
    .tick(tick)
  );

  dpath_alu u_alu
  (
    .op(op_ff),
    .a(alu_a),
    .b(alu_b),
    .cin(psw_ff[`PSW_CY_BIT]),
    .res(alu_res),
    .z(alu_z),
    .hc(alu_hc),
    .cy(alu_cy)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_reg
      reg [7:0] q_ff;
      always @(posedge MCLK or negedge RST_B)
      begin
        if (!RST_B)
          q_ff <= `REG_RESET;
        else if (go && state_ff == S_EXEC && reg_we[gi])
          q_ff <= reg_wd[gi*8 +: 8];
      end
      assign regs_flat[gi*8 +: 8] = q_ff;
    end
  endgenerate

  assign go = tick;
  assign a_val = regs_flat[{`IDX_A, 3'b000} +: 8];
  assign x_val = regs_flat[{`IDX_X, 3'b000} +: 8];
  assign r_val = regs_flat[{reg_ff, 3'b000} +: 8];
  assign ph_val = regs_flat[{pair_ff, 1'b1, 3'b000} +: 8];
  assign pl_val = regs_flat[{pair_ff, 1'b0, 3'b000} +: 8];
  assign hl_val = {regs_flat[{`IDX_H, 3'b000} +: 8], regs_flat[{`IDX_L, 3'b000} +: 8]};
  assign de_val = {regs_flat[{`IDX_D, 3'b000} +: 8], regs_flat[{`IDX_E, 3'b000} +: 8]};

  // Operand checks made at acceptance
  assign cmd_clocks = clocks_of(CMD_OP, CMD_FORM, CMD_DIR, CMD_SRC_IMM, CMD_REG);
  assign in_saddr = (CMD_WORD >= `SADDR_LO) && (CMD_WORD <= `SADDR_HI);
  assign in_table = (CMD_WORD >= `CALL_TABLE_LO) && (CMD_WORD <= `CALL_TABLE_HI) && !CMD_WORD[0];
  assign legal = (cmd_clocks != 4'h0)
    && !(CMD_FORM == `FORM_SADDR && !in_saddr)
    && !(CMD_OP == `OP_MOVE_WORD && CMD_FORM == `FORM_SADDR && CMD_WORD[0])
    && !(CMD_OP == `OP_CALL_TABLE && !in_table)
    && !((CMD_OP == `OP_MOVE_WORD || CMD_OP == `OP_EXCHANGE_WORD) && CMD_FORM == `FORM_REG
      && CMD_PAIR == `PAIR_AX)
    && !((CMD_OP == `OP_MOVE_BYTE || CMD_OP == `OP_EXCHANGE_BYTE) && CMD_FORM == `FORM_REG
      && !CMD_SRC_IMM && CMD_REG == `IDX_A);
  assign is_mem = (CMD_FORM == `FORM_SADDR) || (CMD_FORM == `FORM_SFR) || (CMD_FORM == `FORM_ABS)
    || (CMD_FORM == `FORM_DE) || (CMD_FORM == `FORM_HL) || (CMD_FORM == `FORM_HL_BYTE);
  assign needs_rd = (is_mem && !(CMD_DIR && (CMD_OP == `OP_MOVE_BYTE || CMD_OP == `OP_MOVE_WORD)))
    || (CMD_OP == `OP_CALL_TABLE);

  always @*
  begin
    case (CMD_FORM)
      `FORM_DE: eff_addr = de_val;
      `FORM_HL: eff_addr = hl_val;
      `FORM_HL_BYTE: eff_addr = hl_val + {8'h00, CMD_BYTE};
      default: eff_addr = CMD_WORD;
    endcase
  end

  // Operand and ALU inputs; short direct destination reads its old value
  always @*
  begin
    case (form_ff)
      `FORM_IMM: src_b = byte_ff;
      `FORM_REG: src_b = r_val;
      `FORM_PSW: src_b = psw_ff;
      default: src_b = MEM_RDATA;
    endcase
  end
  assign alu_a = dir_ff ? MEM_RDATA : a_val;
  assign alu_b = dir_ff ? byte_ff : src_b;

  // Execute step: register, status and write-back values
  always @*
  begin
    mv = simm_ff ? byte_ff : a_val;
    reg_we = 8'h00;
    reg_wd = 64'h0;
    psw_nxt = psw_ff;
    wlo_nxt = wdata_ff;
    whi_nxt = whi_ff;
    target_nxt = target_ff;
    case (op_ff)
      `OP_MOVE_BYTE:
        if (!dir_ff)
        begin
          reg_we[`IDX_A] = 1'b1;
          reg_wd[{`IDX_A, 3'b000} +: 8] = src_b;
        end
        else if (form_ff == `FORM_REG)
        begin
          reg_we[reg_ff] = 1'b1;
          reg_wd[{reg_ff, 3'b000} +: 8] = mv;
        end
        else if (form_ff == `FORM_PSW)
          psw_nxt = mv;
        else
          wlo_nxt = mv;
      `OP_EXCHANGE_BYTE:
      begin
        reg_we[`IDX_A] = 1'b1;
        reg_wd[{`IDX_A, 3'b000} +: 8] = src_b;
        if (form_ff == `FORM_REG)
        begin
          reg_we[reg_ff] = 1'b1;
          reg_wd[{reg_ff, 3'b000} +: 8] = a_val;
        end
        else
          wlo_nxt = a_val;
      end
      `OP_MOVE_WORD, `OP_EXCHANGE_WORD:
        if (form_ff == `FORM_SADDR && dir_ff)
        begin
          wlo_nxt = x_val;
          whi_nxt = a_val;
        end
        else if (form_ff == `FORM_SADDR)
        begin
          reg_we[`IDX_A] = 1'b1;
          reg_we[`IDX_X] = 1'b1;
          reg_wd[15:0] = {MEM_RDATA, tmp_ff};
        end
        else
        begin
          if (dir_ff || op_ff == `OP_EXCHANGE_WORD)
          begin
            reg_we[{pair_ff, 1'b1}] = 1'b1;
            reg_we[{pair_ff, 1'b0}] = 1'b1;
            reg_wd[{pair_ff, 1'b1, 3'b000} +: 8] = (form_ff == `FORM_IMM) ? word_ff[15:8] : a_val;
            reg_wd[{pair_ff, 1'b0, 3'b000} +: 8] = (form_ff == `FORM_IMM) ? word_ff[7:0] : x_val;
          end
          if (!dir_ff)
          begin
            reg_we[`IDX_A] = 1'b1;
            reg_we[`IDX_X] = 1'b1;
            reg_wd[15:0] = {ph_val, pl_val};
          end
        end
      `OP_ADD, `OP_ADD_WITH_CARRY, `OP_SUB, `OP_SUBTRACT_WITH_BORROW, `OP_AND, `OP_OR, `OP_XOR:
      begin
        if (dir_ff)
          wlo_nxt = alu_res;
        else
        begin
          reg_we[`IDX_A] = 1'b1;
          reg_wd[{`IDX_A, 3'b000} +: 8] = alu_res;
        end
        psw_nxt[`PSW_Z_BIT] = alu_z;
        if (!op_ff[3])
        begin
          psw_nxt[`PSW_HC_BIT] = alu_hc;
          psw_nxt[`PSW_CY_BIT] = alu_cy;
        end
      end
      `OP_BIT_SET, `OP_BIT_CLEAR:
      begin
        reg_we[`IDX_A] = 1'b1;
        reg_wd[{`IDX_A, 3'b000} +: 8] = (op_ff == `OP_BIT_SET) ? (a_val | (8'h01 << bit_ff)) :
          (a_val & ~(8'h01 << bit_ff));
      end
      `OP_BRANCH_REL: target_nxt = word_ff + {{8{byte_ff[7]}}, byte_ff};
      `OP_CALL_TABLE: target_nxt = {MEM_RDATA, tmp_ff};
      default: target_nxt = target_ff;
    endcase
  end

  // Sequencer: every step but acceptance waits for a CPU clock enable
  always @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_ff <= S_IDLE;
      op_ff <= `OP_MOVE_BYTE;
      form_ff <= `FORM_IMM;
      dir_ff <= 1'b0;
      simm_ff <= 1'b0;
      reg_ff <= 3'h0;
      pair_ff <= 2'h0;
      byte_ff <= 8'h00;
      word_ff <= 16'h0000;
      bit_ff <= 3'h0;
      clocks_ff <= 4'h0;
      cnt_ff <= 4'h0;
      rd_word_ff <= 1'b0;
      wr_ff <= 1'b0;
      wr_word_ff <= 1'b0;
      tmp_ff <= 8'h00;
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      whi_ff <= 8'h00;
      target_ff <= 16'h0000;
      psw_ff <= `PSW_RESET;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      if (state_ff != S_IDLE && go)
        cnt_ff <= cnt_ff + 4'h1;
      case (state_ff)
        S_IDLE:
          if (CMD_VALID)
          begin
            if (!legal)
              err_ff <= 1'b1;
            else
            begin
              op_ff <= CMD_OP;
              form_ff <= CMD_FORM;
              dir_ff <= CMD_DIR;
              simm_ff <= CMD_SRC_IMM;
              reg_ff <= CMD_REG;
              pair_ff <= CMD_PAIR;
              byte_ff <= CMD_BYTE;
              word_ff <= CMD_WORD;
              bit_ff <= CMD_BIT;
              clocks_ff <= cmd_clocks;
              cnt_ff <= 4'h0;
              addr_ff <= eff_addr;
              rd_word_ff <= (CMD_OP == `OP_MOVE_WORD && !CMD_DIR) || (CMD_OP == `OP_CALL_TABLE);
              wr_ff <= is_mem && (CMD_DIR || CMD_OP == `OP_EXCHANGE_BYTE);
              wr_word_ff <= (CMD_OP == `OP_MOVE_WORD) && CMD_DIR;
              state_ff <= needs_rd ? S_RD : S_EXEC;
            end
          end
        S_RD:
          if (go)
          begin
            if (rd_word_ff)
            begin
              addr_ff <= addr_ff + 16'h0001;
              state_ff <= S_RD2;
            end
            else
              state_ff <= S_EXEC;
          end
        S_RD2:
          if (go)
          begin
            tmp_ff <= MEM_RDATA;
            state_ff <= S_EXEC;
          end
        S_EXEC:
          if (go)
          begin
            psw_ff <= psw_nxt;
            wdata_ff <= wlo_nxt;
            whi_ff <= whi_nxt;
            target_ff <= target_nxt;
            state_ff <= wr_ff ? S_WR : S_WAIT;
          end
        S_WR:
          if (go)
          begin
            if (wr_word_ff)
            begin
              addr_ff <= addr_ff + 16'h0001;
              wdata_ff <= whi_ff;
              state_ff <= S_WR2;
            end
            else
              state_ff <= S_WAIT;
          end
        S_WR2:
          if (go)
            state_ff <= S_WAIT;
        S_WAIT:
          if (go && cnt_ff == clocks_ff - 4'h1)
          begin
            done_ff <= 1'b1;
            state_ff <= S_IDLE;
          end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  assign CMD_READY = (state_ff == S_IDLE);
  assign BUSY = (state_ff != S_IDLE);
  assign CMD_DONE = done_ff;
  assign CMD_ERR = err_ff;
  assign TARGET_PC = target_ff;
  assign MEM_ADDR = addr_ff;
  assign MEM_RD = go && (state_ff == S_RD || state_ff == S_RD2);
  assign MEM_WR = go && (state_ff == S_WR || state_ff == S_WR2);
  assign MEM_WDATA = wdata_ff;
  assign PSW_OUT = psw_ff;
  assign ACC_OUT = a_val;
  assign PEEK_DATA = regs_flat[{PEEK_IDX, 3'b000} +: 8];

endmodule

// ### sim/dpath_mem.sv
`timescale 1ns/1ps

module dpath_mem
(
  // Clock
  input wire mclk,
  // Memory bus from the core
  input wire [15:0] addr,
  input wire rd,
  input wire wr,
  input wire [7:0] wdata,
  output logic [7:0] rdata = 8'h00
);
  logic [7:0] cells [0:65535];

  // No wait states; read data holds until the next read strobe
  always @(posedge mclk)
  begin
    if (wr)
      cells[addr] <= wdata;
    if (rd)
      rdata <= cells[addr];
  end
endmodule

// ### sim/dpath_core_checker.sv
`timescale 1ns/1ps
`include "dpath_defines.vh"

module dpath_core_checker
(
  // Clock and reset
  input wire MCLK,
  input wire RST_B,
  // Command
  input wire [1:0] CPU_CLK_SEL,
  input wire CMD_VALID,
  input wire CMD_READY,
  input wire [3:0] CMD_OP,
  input wire [3:0] CMD_FORM,
  input wire CMD_DIR,
  input wire CMD_SRC_IMM,
  input wire [1:0] CMD_PAIR,
  input wire [15:0] CMD_WORD,
  input wire CMD_DONE,
  input wire CMD_ERR,
  // Memory and status
  input wire MEM_RD,
  input wire MEM_WR,
  input wire [7:0] PSW_OUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  wire take = CMD_VALID && CMD_READY;
  wire fast = take && CPU_CLK_SEL == 2'h0;
  wire in_win = CMD_WORD >= `SADDR_LO && CMD_WORD <= `SADDR_HI;
  wire add_imm = CMD_OP == `OP_ADD && CMD_FORM == `FORM_IMM && !CMD_DIR;

  sequence s_rmw;
    MEM_RD ##2 MEM_WR;
  endsequence

  sequence s_slow_done;
    !CMD_DONE [*6] ##[1:3] CMD_DONE;
  endsequence

  chk_add_four: assert property (fast && add_imm |=> !CMD_DONE [*4] ##1 CMD_DONE)
    else $error("add immediate did not finish in four clocks");
  chk_xor_rmw_six: assert property (fast && CMD_OP == `OP_XOR && CMD_FORM == `FORM_SADDR && CMD_DIR && in_win
    && CMD_SRC_IMM |=> s_rmw ##4 CMD_DONE)
    else $error("short direct xor not read, written, done in six clocks");
  chk_and_keeps_cy: assert property (fast && CMD_OP == `OP_AND && CMD_FORM == `FORM_IMM && !CMD_DIR
    |=> ##3 (PSW_OUT & 8'hbf) == ($past(PSW_OUT, 4) & 8'hbf))
    else $error("and changed a flag other than zero");
  chk_xch_no_flag: assert property (fast && CMD_OP == `OP_EXCHANGE_BYTE && CMD_FORM == `FORM_HL_BYTE
    |=> !CMD_DONE [*8] ##1 (CMD_DONE && PSW_OUT == $past(PSW_OUT, 9)))
    else $error("indexed exchange timing or flags wrong");
  chk_pair_ax_err: assert property (take && CMD_FORM == `FORM_REG && !CMD_SRC_IMM && CMD_PAIR == `PAIR_AX
    && (CMD_OP == `OP_MOVE_WORD || CMD_OP == `OP_EXCHANGE_WORD) |=> CMD_ERR)
    else $error("word transfer with pair AX not refused");
  chk_saddr_win: assert property (take && CMD_FORM == `FORM_SADDR && !in_win |=> CMD_ERR)
    else $error("short direct address outside window not refused");
  chk_call_table: assert property (take && CMD_OP == `OP_CALL_TABLE && (CMD_WORD[0]
    || CMD_WORD < `CALL_TABLE_LO || CMD_WORD > `CALL_TABLE_HI) |=> CMD_ERR)
    else $error("bad call table index not refused");
  chk_slow_tick: assert property (take && CPU_CLK_SEL == 2'h1 && add_imm |=> s_slow_done)
    else $error("halved cpu clock count wrong");
endmodule

bind dpath_core dpath_core_checker i_dpath_core_checker (.MCLK, .RST_B, .CPU_CLK_SEL, .CMD_VALID, .CMD_READY,
  .CMD_OP, .CMD_FORM, .CMD_DIR, .CMD_SRC_IMM, .CMD_PAIR, .CMD_WORD, .CMD_DONE, .CMD_ERR, .MEM_RD, .MEM_WR,
  .PSW_OUT);

// ### sim/dpath_core_tb.sv
`timescale 1ns/1ps
`include "dpath_defines.vh"

module dpath_core_tb;
  logic MCLK, RST_B, CMD_VALID, CMD_DIR, CMD_SRC_IMM, err;
  logic CMD_READY, CMD_DONE, CMD_ERR, BUSY, MEM_RD, MEM_WR;
  logic [1:0] CPU_CLK_SEL, CMD_PAIR;
  logic [3:0] CMD_OP, CMD_FORM;
  logic [2:0] CMD_REG, CMD_BIT, PEEK_IDX;
  logic [7:0] CMD_BYTE, MEM_RDATA, MEM_WDATA, PSW_OUT, ACC_OUT, PEEK_DATA;
  logic [15:0] CMD_WORD, TARGET_PC, MEM_ADDR;
  int n_mismatch, n_checks, cyc;

  dpath_core i_dpath_core (.MCLK, .RST_B, .CPU_CLK_SEL, .CMD_VALID, .CMD_READY, .CMD_OP, .CMD_FORM, .CMD_DIR,
    .CMD_SRC_IMM, .CMD_REG, .CMD_PAIR, .CMD_BYTE, .CMD_WORD, .CMD_BIT, .CMD_DONE, .CMD_ERR, .BUSY, .TARGET_PC,
    .MEM_ADDR, .MEM_RD, .MEM_WR, .MEM_WDATA, .MEM_RDATA, .PSW_OUT, .ACC_OUT, .PEEK_IDX, .PEEK_DATA);
  dpath_mem i_dpath_mem (.mclk(MCLK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR), .wdata(MEM_WDATA),
    .rdata(MEM_RDATA));

  initial
  begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_checks++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cycle count starts at the first falling edge after the accepting edge
  task automatic go(input logic [3:0] op, input logic [3:0] fm, input logic [1:0] ds, input logic [2:0] rg,
    input logic [1:0] pr, input logic [7:0] by, input logic [15:0] wd);
    @(negedge MCLK);
    {CMD_OP, CMD_FORM, CMD_DIR, CMD_SRC_IMM, CMD_REG, CMD_BIT, CMD_PAIR, CMD_BYTE, CMD_WORD} =
      {op, fm, ds, rg, rg, pr, by, wd};
    CMD_VALID = 1'b1;
    @(negedge MCLK);
    CMD_VALID = 1'b0;
    chk("busy after accept", {15'h0000, ~CMD_ERR}, {15'h0000, BUSY});
    cyc = 0;
    while (CMD_DONE !== 1'b1 && CMD_ERR !== 1'b1 && cyc < 100)
    begin
      @(negedge MCLK);
      cyc++;
    end
    err = CMD_ERR;
    if (cyc == 100)
    begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic setr(input logic [2:0] r, input logic [7:0] v);
    go(`OP_MOVE_BYTE, `FORM_REG, 2'b11, r, 2'h0, v, 16'h0000);
  endtask

  task automatic setpsw(input logic [7:0] v);
    go(`OP_MOVE_BYTE, `FORM_PSW, 2'b11, 3'h0, 2'h0, v, 16'h0000);
  endtask

  task automatic pk(input logic [2:0] r, input logic [7:0] v);
    PEEK_IDX = r;
    #1;
    chk("register peek", {8'h00, v}, {8'h00, PEEK_DATA});
  endtask

  task automatic t_regs;
    setpsw(8'h21);
    for (int i = 0; i < 8; i++)
    begin
      setr(i[2:0], 8'h10 + i[7:0]);
      chk("move cycles", 16'd6, cyc[15:0]);
    end
    for (int i = 0; i < 8; i++)
      pk(i[2:0], 8'h10 + i[7:0]);
    chk("psw after moves", 16'h0021, {8'h00, PSW_OUT});
    chk("accumulator", 16'h0011, {8'h00, ACC_OUT});
    $display("test regs done");
  endtask

  // Carry-in kept set so the plain ops show they ignore it
  task automatic t_arith;
    logic [7:0] a, b, p;
    logic [8:0] w;
    logic c, h;
    for (int s = 0; s < 2; s++)
      for (int k = 4; k < 11; k++)
      begin
        a = s ? 8'h00 : 8'h8f;
        b = s ? 8'h00 : 8'h71;
        c = k == 5 || k == 7;
        setpsw(8'h21);
        setr(`IDX_A, a);
        go(k[3:0], `FORM_IMM, 2'b00, 3'h0, 2'h0, b, 16'h0000);
        w = (k < 6) ? a + b + c : {1'b0, a} - b - c;
        h = (k < 6) ? ({1'b0, a[3:0]} + b[3:0] + c) > 5'h0f : {1'b0, a[3:0]} < {1'b0, b[3:0]} + c;
        if (k == 8)
          w = {1'b0, a & b};
        if (k == 9)
          w = {1'b0, a | b};
        if (k == 10)
          w = {1'b0, a ^ b};
        p = 8'h21;
        p[6] = w[7:0] == 8'h00;
        if (k < 8)
          {p[4], p[0]} = {h, w[8]};
        chk("alu result", {8'h00, w[7:0]}, {8'h00, ACC_OUT});
        chk("alu flags", {8'h00, p}, {8'h00, PSW_OUT});
        chk("alu cycles", 16'd4, cyc[15:0]);
      end
    $display("test arith done");
  endtask

  task automatic t_saddr;
    i_dpath_mem.cells[16'hfe20] = 8'h5a;
    i_dpath_mem.cells[16'hff1f] = 8'hf8;
    setpsw(8'h00);
    go(`OP_XOR, `FORM_SADDR, 2'b11, 3'h0, 2'h0, 8'h5a, 16'hfe20);
    chk("xor memory", 16'h0000, {8'h00, i_dpath_mem.cells[16'hfe20]});
    chk("xor flags", 16'h0040, {8'h00, PSW_OUT});
    chk("xor cycles", 16'd6, cyc[15:0]);
    go(`OP_ADD, `FORM_SADDR, 2'b11, 3'h0, 2'h0, 8'h08, 16'hff1f);
    chk("add memory", 16'h0000, {8'h00, i_dpath_mem.cells[16'hff1f]});
    chk("add flags", 16'h0051, {8'h00, PSW_OUT});
    chk("add cycles", 16'd6, cyc[15:0]);
    go(`OP_ADD, `FORM_SADDR, 2'b11, 3'h0, 2'h0, 8'h01, 16'hff20);
    chk("above window", 16'h0001, {15'h0000, err});
    go(`OP_ADD, `FORM_SADDR, 2'b11, 3'h0, 2'h0, 8'h01, 16'hfe1f);
    chk("below window", 16'h0001, {15'h0000, err});
    chk("psw after refusal", 16'h0051, {8'h00, PSW_OUT});
    $display("test saddr done");
  endtask

  // Offset 90 lands elsewhere if taken as signed
  task automatic t_hl;
    i_dpath_mem.cells[16'hff80] = 8'h03;
    i_dpath_mem.cells[16'hfe80] = 8'h77;
    setr(`IDX_H, 8'hfe);
    setr(`IDX_L, 8'hf0);
    setr(`IDX_A, 8'h01);
    go(`OP_ADD, `FORM_HL_BYTE, 2'b00, 3'h0, 2'h0, 8'h90, 16'h0000);
    chk("indexed add", 16'h0004, {8'h00, ACC_OUT});
    chk("indexed cycles", 16'd6, cyc[15:0]);
    setpsw(8'h51);
    go(`OP_EXCHANGE_BYTE, `FORM_HL_BYTE, 2'b00, 3'h0, 2'h0, 8'h90, 16'h0000);
    chk("exchange acc", 16'h0003, {8'h00, ACC_OUT});
    chk("exchange memory", 16'h0004, {8'h00, i_dpath_mem.cells[16'hff80]});
    chk("exchange psw", 16'h0051, {8'h00, PSW_OUT});
    chk("exchange cycles", 16'd8, cyc[15:0]);
    $display("test indexed done");
  endtask

  task automatic t_word;
    go(`OP_MOVE_WORD, `FORM_IMM, 2'b11, 3'h0, 2'h1, 8'h00, 16'h1234);
    pk(`IDX_B, 8'h12);
    pk(`IDX_C, 8'h34);
    go(`OP_MOVE_WORD, `FORM_REG, 2'b00, 3'h0, 2'h1, 8'h00, 16'h0000);
    pk(`IDX_A, 8'h12);
    pk(`IDX_X, 8'h34);
    chk("word move cycles", 16'd4, cyc[15:0]);
    go(`OP_EXCHANGE_WORD, `FORM_REG, 2'b00, 3'h0, `PAIR_AX, 8'h00, 16'h0000);
    chk("exchange with AX", 16'h0001, {15'h0000, err});
    go(`OP_MOVE_WORD, `FORM_REG, 2'b00, 3'h0, `PAIR_AX, 8'h00, 16'h0000);
    chk("move with AX", 16'h0001, {15'h0000, err});
    $display("test word done");
  endtask

  task automatic t_misc;
    i_dpath_mem.cells[16'h007e] = 8'hcd;
    i_dpath_mem.cells[16'h007f] = 8'hab;
    go(`OP_CALL_TABLE, `FORM_IMM, 2'b00, 3'h0, 2'h0, 8'h00, 16'h007e);
    chk("table target", 16'habcd, TARGET_PC);
    go(`OP_CALL_TABLE, `FORM_IMM, 2'b00, 3'h0, 2'h0, 8'h00, 16'h0041);
    chk("odd table index", 16'h0001, {15'h0000, err});
    go(`OP_CALL_TABLE, `FORM_IMM, 2'b00, 3'h0, 2'h0, 8'h00, 16'h0080);
    chk("table index high", 16'h0001, {15'h0000, err});
    go(`OP_BRANCH_REL, `FORM_IMM, 2'b00, 3'h0, 2'h0, 8'hfe, 16'h1000);
    chk("backward branch", 16'h0ffe, TARGET_PC);
    $display("test misc done");
  endtask

  // Tick phase at accept is free, so a window of one divider period
  task automatic t_slow;
    for (int d = 1; d < 4; d++)
    begin
      @(negedge MCLK);
      CPU_CLK_SEL = d[1:0];
      go(`OP_ADD, `FORM_IMM, 2'b00, 3'h0, 2'h0, 8'h01, 16'h0000);
      chk("divided cycles", 16'h0001, {15'h0000, cyc >= 3 * (1 << d) + 1 && cyc <= 4 * (1 << d) + 1});
    end
    CPU_CLK_SEL = 2'h0;
    $display("test slow done");
  endtask

  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    RST_B = 1'b0;
    CPU_CLK_SEL = 2'h0;
    CMD_VALID = 1'b0;
    {CMD_OP, CMD_FORM, CMD_DIR, CMD_SRC_IMM, CMD_REG, CMD_BIT, CMD_PAIR, CMD_BYTE, CMD_WORD} = '0;
    PEEK_IDX = 3'h0;
    repeat (10) @(negedge MCLK);
    chk("reset psw", 16'h0000, {8'h00, PSW_OUT});
    chk("reset ready", 16'h0001, {15'h0000, CMD_READY});
    RST_B = 1'b1;
    t_regs();
    t_arith();
    t_saddr();
    t_hl();
    t_word();
    t_misc();
    t_slow();
    close_out();
  end
endmodule
